// File: common/wdt_params.svh
// Constants for the elapsed time watchdog counter.
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH
`define WDT_WORD_W        18
`define WDT_CLK_PERIOD_PS 40000
`define WDT_WORD_TIME_PS  6940000
`define WDT_WORD_CYCLES   (`WDT_WORD_TIME_PS / `WDT_CLK_PERIOD_PS)
`define WDT_TICK_W        8
`define WDT_LOAD_MIN      18'sh3ffe0
`define WDT_LOAD_MAX      18'sh03fdf
`define WDT_FAIL_LIMIT    18'sh3ffe0
`define WDT_RESET_COUNT   18'sh00000
`endif

// File: common/wdt_pkg.sv
// Types shared by the elapsed time watchdog counter.
package wdt_pkg;
  typedef logic signed [17:0] count_word_t;

  typedef struct packed
  {
    logic        valid;
    count_word_t value;
  } load_req_t;

  typedef struct packed
  {
    logic pgm_interrupt;
    logic hw_load;
  } wdt_events_t;

  typedef enum logic [1:0]
  {
    ST_RUN      = 2'b00,
    ST_LOADING  = 2'b01,
    ST_RESUME   = 2'b11
  } wdt_state_t;
endpackage : wdt_pkg

// File: hw/word_time_tick.sv
// Divides the core clock into one pulse per machine word time.
`include "wdt_params.svh"
module word_time_tick
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  output logic      tick
);
  import wdt_pkg::*;

  localparam logic [`WDT_TICK_W-1:0] LAST = (`WDT_TICK_W)'(`WDT_WORD_CYCLES - 1);

  typedef struct packed
  {
    logic [`WDT_TICK_W-1:0] cnt;
    logic                   tick;
  } tick_state_t;

  tick_state_t s_q;
  tick_state_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == LAST)
    begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end
    else
    begin
      s_d.cnt = s_q.cnt + 8'h01;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

  a_tick_period: assert property (@(posedge core_clk) disable iff (!rst_n)
    tick |=> !tick [*8])
    else $error("word tick came too soon");
endmodule : word_time_tick

// File: hw/elapsed_time_watchdog_counter.sv
// Elapsed time clock and watchdog: word-time down-counter with load supervision.
`include "wdt_params.svh"
module elapsed_time_watchdog_counter
(
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  input  wire wdt_pkg::load_req_t   counter_load_instruction,
  input  wire logic                 operate_mode,
  input  wire logic                 supervise_inhibit,
  input  wire logic                 hw_load_done,
  output wdt_pkg::count_word_t      count_value,
  output wdt_pkg::wdt_events_t      events,
  output logic                      loading,
  output logic                      resume_exec
);
  import wdt_pkg::*;

  typedef struct packed
  {
    count_word_t count;
    logic        load_seen;
    logic        fail_latched;
    wdt_state_t  state;
    wdt_events_t ev;
    logic        resume;
  } wdt_core_t;

  // The reset synchroniser lives apart from the core struct, so that no variable has two clocked writers.
  wdt_core_t  s_q;
  wdt_core_t  s_d;
  logic [1:0] rst_pipe_q;
  logic       rst_n;
  logic       tick;
  logic       ld_ok;

  // Clamping keeps an out-of-range load from landing below the failure limit.
  function automatic count_word_t clamp_load(input count_word_t v);
    if (v < `WDT_LOAD_MIN)
    begin
      return `WDT_LOAD_MIN;
    end
    else if (v > `WDT_LOAD_MAX)
    begin
      return `WDT_LOAD_MAX;
    end
    return v;
  endfunction : clamp_load

  assign rst_n = rst_pipe_q[1];
  assign ld_ok = counter_load_instruction.valid && (s_q.state == ST_RUN);

  word_time_tick u_tick
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick     (tick)
  );

  always_comb
  begin
    s_d = s_q;
    s_d.ev = '0;
    s_d.resume = 1'b0;
    case (s_q.state)
      ST_RUN:
      begin
        if (ld_ok)
        begin
          s_d.count = clamp_load(counter_load_instruction.value);
          // A load straight to the limit holds there instead of counting on past it.
          s_d.fail_latched = (s_d.count == `WDT_FAIL_LIMIT);
          if (operate_mode)
          begin
            s_d.load_seen = 1'b1;
            if (s_q.load_seen && !supervise_inhibit)
            begin
              s_d.ev.hw_load = 1'b1;
              s_d.state = ST_LOADING;
            end
          end
        end
        else if (tick && !s_q.fail_latched)
        begin
          s_d.count = s_q.count - 18'sh00001;
          if (s_q.count == 18'sh00001)
          begin
            s_d.ev.pgm_interrupt = 1'b1;
            s_d.load_seen = 1'b0;
          end
          if (s_d.count == `WDT_FAIL_LIMIT)
          begin
            s_d.fail_latched = 1'b1;
            if (!supervise_inhibit)
            begin
              s_d.ev.hw_load = 1'b1;
              s_d.state = ST_LOADING;
            end
          end
        end
      end
      ST_LOADING:
      begin
        if (hw_load_done)
        begin
          s_d.state = ST_RESUME;
        end
      end
      ST_RESUME:
      begin
        s_d.resume = 1'b1;
        s_d.load_seen = 1'b0;
        s_d.state = ST_RUN;
      end
      default:
      begin
        s_d.state = ST_RUN;
      end
    endcase
  end

  // Only the reset synchroniser sees raw rstn; the core clears on the synced copy.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_pipe_q <= 2'b00;
    end
    else
    begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q.count        <= `WDT_RESET_COUNT;
      s_q.load_seen    <= 1'b0;
      s_q.fail_latched <= 1'b1;
      s_q.state        <= ST_RUN;
      s_q.ev           <= '0;
      s_q.resume       <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign count_value = s_q.count;
  assign events      = s_q.ev;
  assign loading     = (s_q.state == ST_LOADING);
  assign resume_exec = s_q.resume;

  a_irq_at_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    events.pgm_interrupt |-> count_value == 18'sh00000)
    else $error("interrupt without counter at zero");

  a_fail_load: assert property (@(posedge core_clk) disable iff (!rst_n)
    ($changed(count_value) && count_value == `WDT_FAIL_LIMIT && !$past(ld_ok) && !$past(supervise_inhibit))
      |-> events.hw_load)
    else $error("limit reached without hardware load");

  a_load_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
    events.hw_load |=> !events.hw_load ##0 loading)
    else $error("hardware load not single pulse");

  a_decrement_one: assert property (@(posedge core_clk) disable iff (!rst_n)
    (tick && s_q.state == ST_RUN && !ld_ok && !s_q.fail_latched) |=> count_value == $past(count_value) - 18'sh00001)
    else $error("counter did not step by one");

  a_load_range: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(ld_ok) |-> (count_value >= `WDT_LOAD_MIN && count_value <= `WDT_LOAD_MAX))
    else $error("loaded value out of range");

  a_second_load: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ld_ok && operate_mode && s_q.load_seen && !supervise_inhibit) |=> events.hw_load)
    else $error("repeated load missed");

  a_inhibit_load: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.state == ST_RUN && supervise_inhibit) |=> !events.hw_load)
    else $error("inhibited supervision forced load");

  a_resume_exec: assert property (@(posedge core_clk) disable iff (!rst_n)
    (loading && hw_load_done) |=> ##1 resume_exec)
    else $error("no resume after hardware load");

  a_irq_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
    events.pgm_interrupt |-> !s_q.load_seen)
    else $error("load count not cleared by interrupt");
endmodule : elapsed_time_watchdog_counter

// File: verification/load_sequencer_model.sv
// Behavioural load sequencer that answers hardware load requests after a set delay.
module load_sequencer_model
(
  input  wire logic       core_clk,
  input  wire logic       load_req,
  input  wire logic [7:0] delay,
  output logic            load_done
);
  timeunit 1ns;
  timeprecision 1ps;
  initial load_done = 1'b0;
  // The tape transfer is only a wait here; memory contents are not visible at the block's ports.
  always @(posedge core_clk)
    if (load_req === 1'b1)
    begin
      repeat (delay) @(posedge core_clk);
      load_done <= 1'b1;
      @(posedge core_clk);
      load_done <= 1'b0;
    end
endmodule : load_sequencer_model

// File: verification/elapsed_time_watchdog_counter_tb_top.sv
// Self-checking bench for the elapsed time watchdog counter.
`include "wdt_params.svh"
module elapsed_time_watchdog_counter_tb_top import wdt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WORD = `WDT_WORD_CYCLES;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  load_req_t   ld = '0;
  logic        op = 1'b0;
  logic        inh = 1'b0;
  logic        done;
  logic [7:0]  dly = 8'h08;
  count_word_t count_value;
  wdt_events_t events;
  logic        loading;
  logic        resume_exec;
  int          err_total = 0;
  int          n_tests = 0;
  int          cnt[3] = '{0, 0, 0};
  int          cyc = 0;
  count_word_t hw_at;
  count_word_t int_at;

  always #20 core_clk = ~core_clk;

  // Sampled on the falling edge, where the registered outputs have settled.
  always @(negedge core_clk)
  begin
    cyc++;
    if (events.hw_load === 1'b1)
    begin
      cnt[0]++;
      hw_at = count_value;
    end
    if (events.pgm_interrupt === 1'b1)
    begin
      cnt[1]++;
      int_at = count_value;
    end
    if (resume_exec === 1'b1)
      cnt[2]++;
  end

  elapsed_time_watchdog_counter i_dut
  (
    .core_clk                 (core_clk),
    .rstn                     (rstn),
    .counter_load_instruction (ld),
    .operate_mode             (op),
    .supervise_inhibit        (inh),
    .hw_load_done             (done),
    .count_value              (count_value),
    .events                   (events),
    .loading                  (loading),
    .resume_exec              (resume_exec)
  );

  load_sequencer_model i_seq
  (
    .core_clk  (core_clk),
    .load_req  (events.hw_load),
    .delay     (dly),
    .load_done (done)
  );

  task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  function automatic int probe(input int k);
    return (k < 3) ? cnt[k] : int'(count_value);
  endfunction : probe

  // Waits for an event counter (0 load, 1 interrupt, 2 resume) or the count (3) to move.
  task automatic wait_for(input int k, input int lim);
    int b;
    b = probe(k);
    for (int i = 0; i < lim && probe(k) == b; i++)
    begin
      @(posedge core_clk);
      #1;
    end
    check("wait", 18'(probe(k) != b), 18'h1);
  endtask : wait_for

  // Holds the load valid for n cycles, so n of two makes back-to-back loads.
  task automatic load(input int v, input int n);
    @(posedge core_clk);
    ld <= '{valid: 1'b1, value: count_word_t'(v)};
    repeat (n) @(posedge core_clk);
    ld.valid <= 1'b0;
    #1;
  endtask : load

  function automatic logic [17:0] exp_load(input int v);
    return 18'((v < -32) ? -32 : (v > 16351) ? 16351 : v);
  endfunction : exp_load

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  initial
  begin
    #(40 * 40000);
    err_total++;
    conclude();
  end

  initial
  begin
    int t;
    int h;
    int vals[$];
    void'($urandom(32'h1813ab48));
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    load(2, 1);
    check("count", count_value, 18'h2);
    wait_for(3, 2 * WORD);
    t = cyc;
    wait_for(3, 2 * WORD);
    check("word_cycles", 18'(cyc - t), 18'(WORD));
    wait_for(0, 40 * WORD);
    check("irq_at", int_at, 18'h0);
    check("fail_at", hw_at, 18'h3ffe0);
    check("loading", 18'(loading), 18'h1);
    wait_for(2, 60);
    check("resumed", 18'(loading), 18'h0);
    check("one_pulse", 18'(cnt[0]), 18'h1);
    $display("end count_down");
    @(posedge core_clk);
    op <= 1'b1;
    dly <= 8'($urandom_range(40, 2));
    h = cnt[0];
    load(100, 2);
    wait_for(0, 4);
    check("repeat", 18'(cnt[0] - h), 18'h1);
    wait_for(2, 60);
    load(1, 1);
    wait_for(1, 3 * WORD);
    h = cnt[0];
    load(50, 1);
    repeat (3) @(posedge core_clk);
    check("after_irq", 18'(cnt[0] - h), 18'h0);
    load(50, 1);
    wait_for(0, 4);
    check("again", 18'(cnt[0] - h), 18'h1);
    wait_for(2, 60);
    $display("end repeat_load");
    @(posedge core_clk);
    inh <= 1'b1;
    h = cnt[0];
    load(10, 2);
    load(-31, 1);
    repeat (3 * WORD) @(posedge core_clk);
    #1;
    check("inhibit", 18'(cnt[0] - h), 18'h0);
    check("held", count_value, 18'h3ffe0);
    $display("end inhibit");
    @(posedge core_clk);
    op <= 1'b0;
    vals = '{-100, 20000, -32, 16351, -1};
    repeat (20) vals.push_back(int'($urandom_range(16383)) - 32);
    foreach (vals[k])
    begin
      load(vals[k], 1);
      check("value", count_value, exp_load(vals[k]));
    end
    $display("end load_values");
    conclude();
  end
endmodule : elapsed_time_watchdog_counter_tb_top
